// ### dpram_pkg.sv
// Constants shared by the dual-port dynamic RAM controller and its array.
// Assumes one 250 MHz clock; all straps are static configuration levels.
// Operation
// - Manage a 16K byte read/write dynamic RAM array.
// - Local processor accesses finish at full speed; a due refresh inserts one wait cycle.
// - RAM is reached through a local port and a system bus port.
// - Local accesses never touch the system bus handshake.
// - Refresh runs automatically, with no software involvement.
// - Local and system bus address windows are chosen independently.
// - Local base may sit on any 16K boundary of the 64K local address space.
// - System bus base may sit on any 16K boundary of a one megabyte space.
// - Optional 8K or 16K local-only segment, invisible on system bus.
package dpram_pkg;
  localparam int RAM_AW      = 14;           // 16K bytes
  localparam int LOC_AW      = 16;           // 64K local space
  localparam int SYS_AW      = 20;           // One megabyte system space
  localparam int DW          = 8;
  localparam int ROWS        = 128;
  localparam int ROW_W       = 7;
  // Refresh: one row every 15.6 us keeps all 128 rows within 2 ms
  localparam int REF_NS      = 15600;
  localparam int CLK_NS      = 4;
  localparam int REF_CYC     = REF_NS / CLK_NS; // Longest time, rounds down
  localparam int REF_CW      = 13;
  // Reserve strap encoding
  localparam logic [1:0] RSV_NONE = 2'h0;
  localparam logic [1:0] RSV_8K   = 2'h1;
  localparam logic [1:0] RSV_16K  = 2'h2;
  localparam logic [RAM_AW-1:0] SEG_8K = 14'h2000;
  typedef enum logic [1:0] {ST_IDLE, ST_LOC, ST_SYS, ST_REF} arb_state_t;
endpackage

// ### dpram_array.sv
// Byte-wide storage cell array standing in for the dynamic RAM devices.
// Assumes at most one access per cycle, chosen by the arbiter above it.
`timescale 1ns/1ps
`default_nettype none
module dpram_array (
  input  wire logic                         sys_clk,
  input  wire logic                         en,
  input  wire logic                         we,
  input  wire logic [dpram_pkg::RAM_AW-1:0] addr,
  input  wire logic [dpram_pkg::DW-1:0]     wdata,
  output logic      [dpram_pkg::DW-1:0]     rdata
);
  logic [dpram_pkg::DW-1:0] mem [0:(1<<dpram_pkg::RAM_AW)-1];
  // Registered read; no reset so it maps to block memory
  always_ff @(posedge sys_clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// ### dpram_ctrl.sv
// Dual-port dynamic RAM controller: local port, system bus port, refresh.
// Assumes request inputs from the bus side are asynchronous and held until
// acknowledged; local port is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dpram_ctrl (
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  // Local processor port, same clock domain
  input  wire logic                         loc_req,
  input  wire logic                         loc_we,
  input  wire logic [dpram_pkg::LOC_AW-1:0] loc_addr,
  input  wire logic [dpram_pkg::DW-1:0]     loc_wdata,
  output logic                              loc_hit,
  output logic                              loc_ack,
  output logic      [dpram_pkg::DW-1:0]     loc_rdata,
  // System bus slave port, asynchronous handshake
  input  wire logic                         sys_req,
  input  wire logic                         sys_we,
  input  wire logic [dpram_pkg::SYS_AW-1:0] sys_addr,
  input  wire logic [dpram_pkg::DW-1:0]     sys_wdata,
  output logic                              sys_ack,
  output logic      [dpram_pkg::DW-1:0]     sys_rdata,
  // Configuration straps, protect pin and refresh row output
  input  wire logic [1:0]                   loc_base,
  input  wire logic [5:0]                   sys_base,
  input  wire logic [1:0]                   reserve_sel,
  input  wire logic                         mem_protect_n,
  output logic      [dpram_pkg::ROW_W-1:0]  refresh_row
);
  // Reset release through two flops
  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // Two-flop synchronisers for off-domain inputs
  logic sreq_s1_reg, sreq_reg, prot_s1_reg, prot_n_reg;
  logic sreq_old_reg;                  // Request already seen a cycle ago
  logic swe_s1_reg, swe_reg;
  logic [dpram_pkg::SYS_AW-1:0] sadr_s1_reg, sadr_reg;
  logic [dpram_pkg::DW-1:0]     swd_s1_reg, swd_reg;
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sreq_s1_reg <= 1'b0;
      sreq_reg    <= 1'b0;
      sreq_old_reg <= 1'b0;
      prot_s1_reg <= 1'b0;
      prot_n_reg  <= 1'b0;
      swe_s1_reg  <= 1'b0;
      swe_reg     <= 1'b0;
      sadr_s1_reg <= 20'h00000;
      sadr_reg    <= 20'h00000;
      swd_s1_reg  <= 8'h00;
      swd_reg     <= 8'h00;
    end else begin
      sreq_s1_reg <= sys_req;
      sreq_reg    <= sreq_s1_reg;
      sreq_old_reg <= sreq_reg;
      prot_s1_reg <= mem_protect_n;
      prot_n_reg  <= prot_s1_reg;
      swe_s1_reg  <= sys_we;
      swe_reg     <= swe_s1_reg;
      sadr_s1_reg <= sys_addr;
      sadr_reg    <= sadr_s1_reg;
      swd_s1_reg  <= sys_wdata;
      swd_reg     <= swd_s1_reg;
    end
  end

  // Local window: 16K block at any 16K boundary of 64K
  function automatic logic loc_decode(input logic [15:0] a,
                                      input logic [1:0] b);
    loc_decode = (a[15:14] == b);
  endfunction

  // System window: 16K block on any 16K boundary of 1M, minus reserve
  function automatic logic sys_decode(input logic [19:0] a,
                                      input logic [5:0] b,
                                      input logic [1:0] r);
    logic in_win;
    in_win = (a[19:14] == b);
    case (r)
      dpram_pkg::RSV_8K:  sys_decode = in_win &&
                            (a[13:0] >= dpram_pkg::SEG_8K);
      dpram_pkg::RSV_16K: sys_decode = 1'b0;
      default:            sys_decode = in_win;
    endcase
  endfunction

  logic loc_sel, sys_sel, prot_on;
  assign loc_sel = loc_req && loc_decode(loc_addr, loc_base);
  // Bus address is decoded only after the request stood a cycle, so an
  // address bit caught one cycle late by its synchroniser is never used
  assign sys_sel = sreq_reg && sreq_old_reg &&
                   sys_decode(sadr_reg, sys_base, reserve_sel);
  assign prot_on = !prot_n_reg;

  // Refresh interval timer and row counter
  logic [dpram_pkg::REF_CW-1:0] ref_cnt_reg, ref_cnt_next;
  logic ref_pend_reg, ref_pend_next;
  logic [dpram_pkg::ROW_W-1:0] row_reg, row_next;
  dpram_pkg::arb_state_t st_reg, st_next;
  logic sys_busy_reg, sys_busy_next;   // Waits for bus to drop request
  logic loc_ack_reg, loc_ack_next, sys_ack_reg, sys_ack_next;
  logic loc_hit_reg, loc_hit_next;
  logic [dpram_pkg::DW-1:0] srd_reg, srd_next;
  logic mem_en, mem_we;
  logic [dpram_pkg::RAM_AW-1:0] mem_addr;
  logic [dpram_pkg::DW-1:0] mem_wd, mem_rd;

  // Arbitration: refresh first, local next, system bus last
  always_comb begin
    ref_cnt_next  = ref_cnt_reg + 13'h0001;
    ref_pend_next = ref_pend_reg;
    row_next      = row_reg;
    st_next       = dpram_pkg::ST_IDLE;
    sys_busy_next = sys_busy_reg && sreq_reg;
    loc_ack_next  = 1'b0;
    sys_ack_next  = sys_ack_reg && sreq_reg;
    loc_hit_next  = loc_sel;
    srd_next      = srd_reg;
    mem_en        = 1'b0;
    mem_we        = 1'b0;
    mem_addr      = loc_addr[13:0];
    mem_wd        = loc_wdata;
    if (ref_cnt_reg == 13'(dpram_pkg::REF_CYC - 1)) begin
      ref_cnt_next  = 13'h0000;
      ref_pend_next = 1'b1;
    end
    case (st_reg)
      dpram_pkg::ST_SYS: begin
        srd_next     = mem_rd;
        sys_ack_next = 1'b1;
      end
      default: begin
      end
    endcase
    if (ref_pend_reg) begin
      ref_pend_next = ref_pend_next &&
                      (ref_cnt_reg == 13'(dpram_pkg::REF_CYC - 1));
      row_next      = row_reg + 7'h01;
      st_next       = dpram_pkg::ST_REF;
    end else if (loc_sel && !prot_on) begin
      mem_en       = 1'b1;
      mem_we       = loc_we;
      loc_ack_next = 1'b1;
      st_next      = dpram_pkg::ST_LOC;
    end else if (sys_sel && !sys_busy_reg && !prot_on &&
                 st_reg != dpram_pkg::ST_SYS) begin
      mem_en        = 1'b1;
      mem_we        = swe_reg;
      mem_addr      = sadr_reg[13:0];
      mem_wd        = swd_reg;
      sys_busy_next = 1'b1;
      st_next       = dpram_pkg::ST_SYS;
    end
    if (prot_on) begin
      loc_ack_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ref_cnt_reg  <= 13'h0000;
      ref_pend_reg <= 1'b0;
      row_reg      <= 7'h00;
      st_reg       <= dpram_pkg::ST_IDLE;
      sys_busy_reg <= 1'b0;
      loc_ack_reg  <= 1'b0;
      sys_ack_reg  <= 1'b0;
      loc_hit_reg  <= 1'b0;
      srd_reg      <= 8'h00;
    end else begin
      ref_cnt_reg  <= ref_cnt_next;
      ref_pend_reg <= ref_pend_next;
      row_reg      <= row_next;
      st_reg       <= st_next;
      sys_busy_reg <= sys_busy_next;
      loc_ack_reg  <= loc_ack_next;
      sys_ack_reg  <= sys_ack_next;
      loc_hit_reg  <= loc_hit_next;
      srd_reg      <= srd_next;
    end
  end

  // Refresh owns the array for its cycle; no port may slip in
  property p_ref_first;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      ref_pend_reg |-> !mem_en;
  endproperty
  a_ref_first: assert property (p_ref_first)
    else $error("port access during a refresh cycle");

  // On a tie the local port is served first
  property p_loc_wins;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      loc_sel && sys_sel && !ref_pend_reg && !prot_on |=>
        st_reg == dpram_pkg::ST_LOC;
  endproperty
  a_loc_wins: assert property (p_loc_wins)
    else $error("local port lost a tie to the bus port");

  // Local hits are answered on the next edge, no wait states
  property p_loc_speed;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      loc_sel && !ref_pend_reg && !prot_on |=> loc_ack;
  endproperty
  a_loc_speed: assert property (p_loc_speed)
    else $error("local access not answered on the next edge");

  // Bus acknowledge stands while the request is held
  property p_sys_hold;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      sys_ack && sreq_reg |=> sys_ack;
  endproperty
  a_sys_hold: assert property (p_sys_hold)
    else $error("bus acknowledge dropped under a held request");

  // Each refresh cycle moves on by exactly one row
  property p_ref_row;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      ref_pend_reg |=> refresh_row == 7'($past(refresh_row) + 7'h01);
  endproperty
  a_ref_row: assert property (p_ref_row)
    else $error("refresh row did not step by one");

  // Protect shuts both ports out of the array
  property p_protect;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      prot_on |-> !mem_en && !loc_ack_next;
  endproperty
  a_protect: assert property (p_protect)
    else $error("array reached while protected");

  // Local hits only inside the chosen 16K window
  property p_loc_window;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      loc_sel |-> loc_addr[15:14] == loc_base;
  endproperty
  a_loc_window: assert property (p_loc_window)
    else $error("local hit outside its window");

  // Bus hits only inside its window and never in the reserved part
  property p_sys_window;
    @(posedge sys_clk) disable iff (!rst_n_reg)
      sys_sel |-> sadr_reg[19:14] == sys_base &&
                  reserve_sel != dpram_pkg::RSV_16K &&
                  !(reserve_sel == dpram_pkg::RSV_8K &&
                    sadr_reg[13:0] < dpram_pkg::SEG_8K);
  endproperty
  a_sys_window: assert property (p_sys_window)
    else $error("bus hit outside its window or in reserved RAM");

  // Scenario coverage: port tie, bus grant, protected local request
  c_port_tie: cover property (@(posedge sys_clk) disable iff (!rst_n_reg)
    loc_sel && sys_sel);
  c_sys_grant: cover property (@(posedge sys_clk) disable iff (!rst_n_reg)
    st_reg == dpram_pkg::ST_SYS);
  c_prot_hold: cover property (@(posedge sys_clk) disable iff (!rst_n_reg)
    prot_on && loc_sel);

  dpram_array u_array (
    .sys_clk (sys_clk),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wd),
    .rdata   (mem_rd)
  );

  assign loc_ack     = loc_ack_reg;
  assign loc_hit     = loc_hit_reg;
  assign loc_rdata   = mem_rd;
  assign sys_ack     = sys_ack_reg;
  assign sys_rdata   = srd_reg;
  assign refresh_row = row_reg;
endmodule
`default_nettype wire

// ### sys_master_model.sv
// Stand-in for another master on the shared system bus.
// Assumes the controller answers each held request with sys_ack.
`timescale 1ns/1ps
`default_nettype none
module sys_master_model (
  input  wire logic                         sys_clk,
  input  wire logic                         sys_ack,
  input  wire logic [dpram_pkg::DW-1:0]     sys_rdata,
  output logic                              sys_req,
  output logic                              sys_we,
  output logic      [dpram_pkg::SYS_AW-1:0] sys_addr,
  output logic      [dpram_pkg::DW-1:0]     sys_wdata
);
  // No request on the bus before the first transfer
  initial begin
    sys_req   = 1'b0;
    sys_we    = 1'b0;
    sys_addr  = 20'h00000;
    sys_wdata = 8'h00;
  end
  // Idle address and data lines show inverted values so stale data never looks valid
  // Four-phase: the task returns only once acknowledge has dropped again,
  // so the next call can never take a stale acknowledge
  task automatic access(input logic w, input logic [19:0] a,
                        input logic [7:0] d, output logic ok,
                        output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    sys_req   <= 1'b1;
    sys_we    <= w;
    sys_addr  <= a;
    sys_wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sys_ack !== 1'b1 && n < 40);
    ok = (sys_ack === 1'b1);
    q = sys_rdata;
    sys_req   <= 1'b0;
    sys_addr  <= ~a;
    sys_wdata <= ~d;
    n = 0;
    while (sys_ack !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    ok = ok && (sys_ack === 1'b0);
  endtask
endmodule
`default_nettype wire

// ### tb_dpram_ctrl.sv
// Self-checking bench for the dual-port RAM controller.
// Assumes a 16K local window per loc_base step and per sys_base step.
`timescale 1ns/1ps
`default_nettype none
module tb_dpram_ctrl;
  logic       sys_clk, rstn, loc_req, loc_we, loc_hit, loc_ack;
  logic       sys_req, sys_we, sys_ack, mem_protect_n;
  logic [15:0] loc_addr;
  logic [19:0] sys_addr;
  logic [7:0]  loc_wdata, loc_rdata, sys_wdata, sys_rdata, q;
  logic [1:0]  loc_base, reserve_sel;
  logic [5:0]  sys_base;
  logic [6:0]  refresh_row, row0;
  logic        ok, ok2, hit;
  int          n_errors, checks, cyc;
  dpram_ctrl u_dpram_ctrl (.sys_clk(sys_clk), .rstn(rstn),
    .loc_req(loc_req), .loc_we(loc_we), .loc_addr(loc_addr),
    .loc_wdata(loc_wdata), .loc_hit(loc_hit), .loc_ack(loc_ack),
    .loc_rdata(loc_rdata), .sys_req(sys_req), .sys_we(sys_we),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
    .sys_rdata(sys_rdata), .loc_base(loc_base), .sys_base(sys_base),
    .reserve_sel(reserve_sel), .mem_protect_n(mem_protect_n),
    .refresh_row(refresh_row));
  sys_master_model u_sys_master_model (.sys_clk(sys_clk),
    .sys_ack(sys_ack), .sys_rdata(sys_rdata), .sys_req(sys_req),
    .sys_we(sys_we), .sys_addr(sys_addr), .sys_wdata(sys_wdata));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Cuts a hang short; the refresh wait is the longest step
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Local cycle: request held until acknowledged, data taken at that edge
  task automatic loc_acc(input logic w, input logic [15:0] a,
                         input logic [7:0] d, output logic k);
    int n;
    n = 0;
    @(posedge sys_clk);
    loc_req <= 1'b1;
    loc_we <= w;
    loc_addr <= a;
    loc_wdata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (loc_ack !== 1'b1 && n < 16);
    k = (loc_ack === 1'b1);
    q = loc_rdata;
    hit = loc_hit;
    loc_req <= 1'b0;
    loc_wdata <= ~d;
  endtask
  task automatic t_ports;
    loc_acc(1'b1, 16'h4005, 8'hA5, ok);
    chk(ok, "local write");
    u_sys_master_model.access(1'b0, 20'h14005, 8'h00, ok, q);
    chk(ok && q === 8'hA5, "bus sees local data");
    u_sys_master_model.access(1'b1, 20'h14007, 8'h5A, ok, q);
    loc_acc(1'b0, 16'h4007, 8'h00, ok);
    chk(ok && q === 8'h5A && hit === 1'b1, "local sees bus data");
    loc_acc(1'b0, 16'hC005, 8'h00, ok);
    chk(!ok && hit === 1'b0, "no answer outside window");
  endtask
  task automatic t_both;
    logic [7:0] qs;
    fork
      begin
        // Local starts late so both requests meet at the arbiter
        repeat (2) @(posedge sys_clk);
        loc_acc(1'b0, 16'h4005, 8'h00, ok);
      end
      u_sys_master_model.access(1'b0, 20'h14007, 8'h00, ok2, qs);
    join
    chk(ok && ok2 && q === 8'hA5 && qs === 8'h5A, "both served");
  endtask
  task automatic t_guard;
    reserve_sel <= dpram_pkg::RSV_16K;
    u_sys_master_model.access(1'b0, 20'h14005, 8'h00, ok, q);
    chk(!ok, "reserved RAM hidden from bus");
    reserve_sel <= dpram_pkg::RSV_8K;
    u_sys_master_model.access(1'b0, 20'h14005, 8'h00, ok, q);
    chk(!ok, "low 8K hidden from bus");
    u_sys_master_model.access(1'b1, 20'h16000, 8'h3C, ok, q);
    loc_acc(1'b0, 16'h6000, 8'h00, ok2);
    chk(ok && ok2 && q === 8'h3C, "upper 8K still shared");
    reserve_sel <= dpram_pkg::RSV_NONE;
    mem_protect_n <= 1'b0;
    // Protect passes a two-flop synchroniser before it takes hold
    repeat (3) @(posedge sys_clk);
    loc_acc(1'b1, 16'h4005, 8'h00, ok);
    chk(!ok, "protect blocks access");
    u_sys_master_model.access(1'b1, 20'h14005, 8'h00, ok2, q);
    chk(!ok2, "protect blocks bus access");
    mem_protect_n <= 1'b1;
    loc_acc(1'b0, 16'h4005, 8'h00, ok);
    chk(ok && q === 8'hA5, "contents kept");
  endtask
  task automatic t_ref;
    row0 = refresh_row;
    // Any run of one refresh interval holds exactly one row step
    repeat (dpram_pkg::REF_CYC) @(posedge sys_clk);
    chk(refresh_row === 7'(row0 + 7'h01), "refresh advances");
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {rstn, loc_req, loc_we} = '0;
    {loc_addr, loc_wdata} = '0;
    {loc_base, sys_base, reserve_sel, mem_protect_n} = {2'h1, 6'h05, 3'h1};
    n_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_ports();
    t_both();
    t_guard();
    t_ref();
    final_report();
  end
endmodule
`default_nettype wire
